// [rtl/core_seq_regs.svh]
// Offsets, field positions, reset values and rule summary of the core sequencing block
// Function
// - Page preselect bits pick one of four 512-word program pages.
// - Watchdog expiry flag is 1 after power-up, watchdog clear or sleep; 0 on time-out.
// - Sleep entered flag 1 after power-up or watchdog clear, 0 after sleep; read-only.
// - Zero flag follows whether a flag-affecting result is zero; rotates keep it unchanged.
// - Half carry is low-nibble carry on add, no-borrow on subtract.
// - Carry is add carry, subtract no-borrow, or bit rotated out.
// - Load config copies working register into six-bit config; reset sets all ones.
// - Config bit 5 picks external pin or instruction clock for the timer.
// - Config bit 4 picks falling or rising edge of the external pin.
// - Config bit 3 gives the shared prescaler to watchdog or timer.
// - Ratio n divides timer by 2^(n+1), watchdog by 2^n.
// - Program counter advances by one each valid instruction cycle unless loaded.
// - Jump loads counter bits 8..0; pc low byte maps onto bits 7..0.
// - Status bits 5 and 6 supply counter bits 9 and 10 on loads.
// - Call or pc low byte write loads bits 7..0 and clears bit 8.
// - Page preselect bits stay unchanged when increment crosses a page.
// - Reset sets all counter bits and clears the page preselect bits.
// - Two-level stack; call moves level 1 to 2, pushes counter plus one.
// - Return literal pops level 1 to counter, copies level 2 to 1, loads literal.
// - Indirect data port accesses the memory location named by the pointer.
// - Pointer zero: indirect read gives 00h, indirect write stores nothing.
// - Status as destination of a flag-affecting op keeps computed Z, DC, C.
// - Pointer bits 4..0 pick address; bits 6..5 bank or read as 1.
`ifndef CORE_SEQ_REGS_SVH
`define CORE_SEQ_REGS_SVH

`define ADDR_INDIRECT 7'h00
`define ADDR_TIMER_COUNT 7'h01
`define ADDR_PC_LOW 7'h02
`define ADDR_STATUS 7'h03
`define ADDR_POINTER 7'h04

`define ST_CARRY 0
`define ST_HALF_CARRY 1
`define ST_ZERO 2
`define ST_SLEEP 3
`define ST_WDOG 4
`define ST_PAGE_LO 5
`define ST_PAGE_HI 6
`define ST_SPARE 7

`define CFG_SOURCE 5
`define CFG_EDGE 4
`define CFG_OWNER 3
`define CFG_RESET 6'h3f
`define SYNC_STAGES 3

`endif

// [rtl/core_seq_pkg.sv]
// Types shared by the core sequencing block
package core_seq_pkg;
  typedef enum logic [3:0] {
    ALU_NONE = 4'h0,
    ALU_ADD = 4'h1,
    ALU_SUB = 4'h2,
    ALU_RRF = 4'h3,
    ALU_RLF = 4'h4,
    ALU_LOGIC = 4'h5
  } alu_op_t;

  typedef enum logic [3:0] {
    FLOW_STEP = 4'h1,
    FLOW_JUMP = 4'h2,
    FLOW_CALL = 4'h4,
    FLOW_RETURN = 4'h8
  } flow_t;
endpackage

// [rtl/prescale_select.sv]
// Timer source, edge and shared prescaler routing from the config register
`timescale 1ns/1ps
module prescale_select
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [5:0] configBits,
  input wire logic timerExtClockPin,
  input wire logic watchdogTick,
  output logic timerTick,
  output logic watchdogTimeout
);
  `include "core_seq_regs.svh"

  logic [`SYNC_STAGES-1:0] pinSync_reg;
  logic [`SYNC_STAGES-1:0] pinSync_next;
  logic pinLevel_reg;
  logic pinLevel_next;
  logic [7:0] scale_reg;
  logic [7:0] scale_next;
  logic [7:0] scaleTap;
  logic srcTick;
  logic prescaledTick;
  logic [7:0] carryMask;

  always_comb
  begin
    pinSync_next = {pinSync_reg[`SYNC_STAGES-2:0], timerExtClockPin};
    pinLevel_next = pinLevel_reg;
    // Stages two and three must agree before the level counts
    if (pinSync_reg[1] == pinSync_reg[2])
    begin
      pinLevel_next = pinSync_reg[2];
    end
  end

  always_comb
  begin
    srcTick = 1'b1;
    if (configBits[`CFG_SOURCE])
    begin
      if (configBits[`CFG_EDGE])
      begin
        srcTick = pinLevel_reg & ~pinLevel_next;
      end
      else
      begin
        srcTick = ~pinLevel_reg & pinLevel_next;
      end
    end
    // Single prescaler, fed by whichever side owns it
    prescaledTick = configBits[`CFG_OWNER] ? watchdogTick : srcTick;
    scale_next = prescaledTick ? scale_reg + 8'h01 : scale_reg;
    carryMask = (8'h02 << configBits[2:0]) - 8'h01;
    scaleTap = scale_reg & carryMask;
    // Timer sees 2^(n+1); watchdog 2^n, so ratio 000 passes every tick
    if (configBits[`CFG_OWNER])
    begin
      timerTick = srcTick;
      watchdogTimeout = watchdogTick &
        ((configBits[2:0] == 3'h0) || ((scaleTap >> 1) == (carryMask >> 1)));
    end
    else
    begin
      timerTick = prescaledTick && (scaleTap == carryMask);
      watchdogTimeout = watchdogTick;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinSync_reg <= '0;
      pinLevel_reg <= 1'b0;
      scale_reg <= 8'h00;
    end
    else
    begin
      pinSync_reg <= pinSync_next;
      pinLevel_reg <= pinLevel_next;
      scale_reg <= scale_next;
    end
  end
endmodule // prescale_select

// [rtl/core_pc_status_stack.sv]
// Status flags, config register, program counter, return stack and indirect addressing
`timescale 1ns/1ps
module core_pc_status_stack
#(
  parameter int PC_WIDTH = 11,
  parameter bit BANKED = 1'b1
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire core_seq_pkg::flow_t flow,
  input wire logic [8:0] jumpTarget,
  input wire logic [7:0] literal,
  input wire logic instrValid,
  input wire logic loadConfig,
  input wire logic [7:0] workingReg,
  input wire logic watchdogClear,
  input wire logic sleepInstr,
  input wire logic watchdogTick,
  input wire logic timerExtClockPin,
  input wire core_seq_pkg::alu_op_t aluOp,
  input wire logic [7:0] aluA,
  input wire logic [7:0] aluB,
  input wire logic [7:0] aluResult,
  input wire logic flagWrite,
  input wire logic [6:0] fileAddr,
  input wire logic fileWrite,
  input wire logic [7:0] fileWriteData,
  input wire logic [7:0] memReadData,
  output logic [PC_WIDTH-1:0] pc,
  output logic [7:0] statusOut,
  output logic [6:0] pointerOut,
  output logic [6:0] memAddr,
  output logic memWrite,
  output logic [7:0] memWriteData,
  output logic [7:0] fileReadData,
  output logic retLiteralLoad,
  output logic [7:0] retLiteral,
  output logic timerTick,
  output logic watchdogTimeout
);
  import core_seq_pkg::*;
  `include "core_seq_regs.svh"

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [PC_WIDTH-1:0] pagedLoad(input logic [8:0] low,
                                                   input logic [1:0] page);
    logic [10:0] full;
    full = {page, low};
    return full[PC_WIDTH-1:0];
  endfunction

  function automatic logic [6:0] pointerView(input logic [6:0] p);
    return BANKED ? p : {2'b11, p[4:0]};
  endfunction

  // Core registers repeat in every bank, so only the low five bits count
  function automatic logic hitsReg(input logic [6:0] a, input logic [6:0] target);
    return a[4:0] == target[4:0];
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [PC_WIDTH-1:0] pc_reg;
  logic [PC_WIDTH-1:0] pc_next;
  logic [PC_WIDTH-1:0] stack_reg [2];
  logic [PC_WIDTH-1:0] stack_next [2];
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [5:0] config_reg;
  logic [5:0] config_next;
  logic [6:0] pointer_reg;
  logic [6:0] pointer_next;
  logic [7:0] retLit_reg;
  logic [7:0] retLit_next;
  logic retLoad_reg;
  logic retLoad_next;
  logic watchdogTimeoutInt;
  logic [4:0] sumLow;
  logic [8:0] sumFull;
  logic isIndirect;
  logic indirectNull;
  logic [6:0] effAddr;
  logic [1:0] page;
  logic [PC_WIDTH-1:0] pcPlusOne;

  // ****************************************
  // Timer source and shared prescaler
  // ****************************************
  prescale_select u_prescale
  (
    .clk(clk),
    .reset_n(reset_n),
    .configBits(config_reg),
    .timerExtClockPin(timerExtClockPin),
    .watchdogTick(watchdogTick),
    .timerTick(timerTick),
    .watchdogTimeout(watchdogTimeoutInt)
  );

  // ****************************************
  // Indirect addressing
  // ****************************************
  always_comb
  begin
    isIndirect = fileAddr == `ADDR_INDIRECT;
    effAddr = isIndirect ? pointerView(pointer_reg) : fileAddr;
    indirectNull = isIndirect && (pointer_reg[4:0] == 5'h00);
    memAddr = effAddr;
    // Indirect write through pointer 0 goes nowhere
    memWrite = instrValid && fileWrite && !indirectNull && (effAddr[4:0] > 5'h04);
    memWriteData = fileWriteData;
    fileReadData = memReadData;
    if (indirectNull)
    begin
      fileReadData = 8'h00;
    end
    else
    begin
      case (effAddr[4:0])
        5'h02: fileReadData = pc_reg[7:0];
        5'h03: fileReadData = status_reg;
        5'h04: fileReadData = {1'b1, pointerView(pointer_reg)};
        default: fileReadData = memReadData;
      endcase
    end
  end

  always_comb
  begin
    pointer_next = pointer_reg;
    if (instrValid && fileWrite && !indirectNull && hitsReg(effAddr, `ADDR_POINTER))
    begin
      pointer_next = fileWriteData[6:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pointer_reg <= 7'h00;
    end
    else
    begin
      pointer_reg <= pointer_next;
    end
  end

  // ****************************************
  // Status flags and config
  // ****************************************
  always_comb
  begin
    status_next = status_reg;
    config_next = config_reg;
    sumLow = 5'h00;
    sumFull = 9'h000;
    if (instrValid && fileWrite && !indirectNull)
    begin
      if (hitsReg(effAddr, `ADDR_STATUS))
      begin
        // Flag bits 4 and 3 are read-only
        status_next[7:5] = fileWriteData[7:5];
        if (!flagWrite)
        begin
          status_next[2:0] = fileWriteData[2:0];
        end
      end
    end
    if (instrValid && flagWrite)
    begin
      // Computed flags win over a direct write of the status byte
      status_next[`ST_ZERO] = aluResult == 8'h00;
      case (aluOp)
        ALU_ADD:
        begin
          sumLow = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]};
          sumFull = {1'b0, aluA} + {1'b0, aluB};
          status_next[`ST_HALF_CARRY] = sumLow[4];
          status_next[`ST_CARRY] = sumFull[8];
        end
        ALU_SUB:
        begin
          // aluA minus aluB, flags show no-borrow
          status_next[`ST_HALF_CARRY] = aluA[3:0] >= aluB[3:0];
          status_next[`ST_CARRY] = aluA >= aluB;
        end
        ALU_RRF: status_next[`ST_CARRY] = aluA[0];
        ALU_RLF: status_next[`ST_CARRY] = aluA[7];
        default: status_next = status_next;
      endcase
      if (aluOp == ALU_RRF || aluOp == ALU_RLF)
      begin
        status_next[`ST_ZERO] = status_reg[`ST_ZERO];
      end
    end
    if (instrValid && watchdogClear)
    begin
      status_next[`ST_WDOG] = 1'b1;
      status_next[`ST_SLEEP] = 1'b1;
    end
    if (instrValid && sleepInstr)
    begin
      status_next[`ST_WDOG] = 1'b1;
      status_next[`ST_SLEEP] = 1'b0;
    end
    // Time-out is a hardware event and wins over a clear in the same cycle
    if (watchdogTimeoutInt)
    begin
      status_next[`ST_WDOG] = 1'b0;
    end
    if (instrValid && loadConfig)
    begin
      config_next = workingReg[5:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_reg <= 8'h18;
      config_reg <= `CFG_RESET;
    end
    else
    begin
      status_reg <= status_next;
      config_reg <= config_next;
    end
  end

  // ****************************************
  // Program counter and stack
  // ****************************************
  always_comb
  begin
    page = status_reg[`ST_PAGE_HI:`ST_PAGE_LO];
    pcPlusOne = pc_reg + 1'b1;
    pc_next = pc_reg;
    stack_next = stack_reg;
    retLit_next = retLit_reg;
    retLoad_next = 1'b0;
    if (instrValid)
    begin
      pc_next = pcPlusOne;
      case (flow)
        FLOW_JUMP: pc_next = pagedLoad(jumpTarget, page);
        FLOW_CALL:
        begin
          stack_next[1] = stack_reg[0];
          stack_next[0] = pcPlusOne;
          pc_next = pagedLoad({1'b0, jumpTarget[7:0]}, page);
        end
        FLOW_RETURN:
        begin
          pc_next = stack_reg[0];
          stack_next[0] = stack_reg[1];
          retLit_next = literal;
          retLoad_next = 1'b1;
        end
        default:
        begin
          if (fileWrite && !indirectNull && hitsReg(effAddr, `ADDR_PC_LOW))
          begin
            pc_next = pagedLoad({1'b0, fileWriteData}, page);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_reg <= '1;
      stack_reg[0] <= '0;
      stack_reg[1] <= '0;
      retLit_reg <= 8'h00;
      retLoad_reg <= 1'b0;
    end
    else
    begin
      pc_reg <= pc_next;
      stack_reg <= stack_next;
      retLit_reg <= retLit_next;
      retLoad_reg <= retLoad_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pc = pc_reg;
  assign statusOut = status_reg;
  assign pointerOut = pointerView(pointer_reg);
  assign retLiteral = retLit_reg;
  assign retLiteralLoad = retLoad_reg;
  assign watchdogTimeout = watchdogTimeoutInt;
endmodule // core_pc_status_stack

// [verif/core_pc_status_stack_properties.sv]
// Port assertions for the core sequencing block
`timescale 1ns/1ps
module core_pc_status_stack_properties
#(
  parameter int PC_WIDTH = 11,
  parameter bit BANKED = 1'b1
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire core_seq_pkg::flow_t flow,
  input wire logic [8:0] jumpTarget,
  input wire logic [7:0] literal,
  input wire logic instrValid,
  input wire logic sleepInstr,
  input wire logic fileWrite,
  input wire logic [6:0] fileAddr,
  input wire logic [PC_WIDTH-1:0] pc,
  input wire logic [7:0] statusOut,
  input wire logic [6:0] pointerOut,
  input wire logic [6:0] memAddr,
  input wire logic memWrite,
  input wire logic [7:0] fileReadData,
  input wire logic retLiteralLoad,
  input wire logic [7:0] retLiteral,
  input wire logic watchdogTimeout
);
  import core_seq_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Plain instruction: no file write, no time-out interfering
  logic ld;
  assign ld = instrValid && !fileWrite && !watchdogTimeout;
  // ****************************************
  // Counter, stack and status
  // ****************************************
  a_pc_step: assert property (ld && flow == FLOW_STEP |=> pc == PC_WIDTH'($past(pc) + 1'b1))
    else $error("pc did not advance");
  a_jump_load: assert property (ld && flow == FLOW_JUMP
    |=> pc == PC_WIDTH'({$past(statusOut[6:5]), $past(jumpTarget)}))
    else $error("jump load wrong");
  a_call_load: assert property (ld && flow == FLOW_CALL
    |=> pc == PC_WIDTH'({$past(statusOut[6:5]), 1'b0, $past(jumpTarget[7:0])}))
    else $error("call load wrong");
  a_call_ret: assert property (ld && flow == FLOW_CALL ##1 ld && flow == FLOW_RETURN
    |=> pc == PC_WIDTH'($past(pc, 2) + 1'b1))
    else $error("return address wrong");
  a_ret_literal: assert property (ld && flow == FLOW_RETURN
    |=> retLiteralLoad && retLiteral == $past(literal))
    else $error("return literal wrong");
  a_page_hold: assert property (ld |=> $stable(statusOut[6:5]))
    else $error("page bits changed");
  a_sleep_flags: assert property (instrValid && sleepInstr && !watchdogTimeout
    |=> statusOut[4:3] == 2'b10)
    else $error("sleep flags wrong");
  a_timeout_flag: assert property (watchdogTimeout |=> !statusOut[4])
    else $error("time-out flag not cleared");
  // ****************************************
  // Indirect port
  // ****************************************
  a_ind_zero: assert property (fileAddr == 7'h00 && pointerOut == 7'h00
    |-> fileReadData == 8'h00 && !memWrite)
    else $error("null pointer access leaked");
  a_ind_addr: assert property (fileAddr == 7'h00 |-> memAddr == pointerOut)
    else $error("indirect address wrong");
  c_call: cover property (ld && flow == FLOW_CALL ##1 ld && flow == FLOW_RETURN);
  c_sleep: cover property (instrValid && sleepInstr);
  c_timeout: cover property (watchdogTimeout);
endmodule // core_pc_status_stack_properties

bind core_pc_status_stack core_pc_status_stack_properties
  #(.PC_WIDTH(PC_WIDTH), .BANKED(BANKED)) props_inst (.*);

// [verif/core_pc_status_stack_test.sv]
// Self-checking bench for the core sequencing block
`timescale 1ns/1ps
module core_pc_status_stack_test;
  import core_seq_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  flow_t flow = FLOW_STEP;
  alu_op_t aluOp = ALU_NONE;
  logic [8:0] jumpTarget = 9'h000;
  logic [7:0] literal = 8'h00, workingReg = 8'h00, aluA = 8'h00, aluB = 8'h00;
  logic [7:0] aluResult = 8'h00, fileWriteData = 8'h00, memReadData;
  logic instrValid = 1'b0, loadConfig = 1'b0, watchdogClear = 1'b0, sleepInstr = 1'b0;
  logic watchdogTick = 1'b0, timerExtClockPin = 1'b0, flagWrite = 1'b0, fileWrite = 1'b0;
  logic [6:0] fileAddr = 7'h10;
  logic [10:0] pc, expPc, stk1, stk2;
  logic [7:0] statusOut, memWriteData, fileReadData, retLiteral, expSt;
  logic [6:0] pointerOut, memAddr;
  logic memWrite, retLiteralLoad, timerTick, watchdogTimeout;
  integer seed = 32'h54ca195a;
  logic [31:0] r;
  int error_cnt = 0;
  int checked = 0;
  alu_op_t ops[5] = '{ALU_ADD, ALU_SUB, ALU_RRF, ALU_RLF, ALU_LOGIC};
  logic [6:0] ptrT[5] = '{7'h00, 7'h08, 7'h1f, 7'h45, 7'h7f};
  logic [5:0] cfgT[9] = '{6'h00, 6'h01, 6'h02, 6'h08, 6'h38, 6'h28, 6'h08, 6'h09, 6'h0a};
  int expT[9] = '{32, 16, 8, 64, 8, 8, 64, 32, 16};

  core_pc_status_stack core_pc_status_stack_inst (.*);

  // Memory stand-in: data is a known function of the address
  assign memReadData = {1'b0, memAddr} ^ 8'h5a;
  always #25 clk = ~clk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #5;
  endtask

  task automatic close_out;
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Returns {result, new status} of one flag-affecting operation
  function automatic logic [15:0] alu_exp(input alu_op_t o, input logic [7:0] a, b, st);
    logic [7:0] res;
    case (o)
      ALU_ADD:
      begin
        res = a + b;
        st[1] = ({1'b0, a[3:0]} + b[3:0]) > 5'h0f;
        st[0] = ({1'b0, a} + b) > 9'h0ff;
      end
      ALU_SUB:
      begin
        res = a - b;
        st[1] = a[3:0] >= b[3:0];
        st[0] = a >= b;
      end
      ALU_RRF:
      begin
        res = {st[0], a[7:1]};
        st[0] = a[0];
      end
      ALU_RLF:
      begin
        res = {a[6:0], st[0]};
        st[0] = a[7];
      end
      default: res = a & b;
    endcase
    if (o != ALU_RRF && o != ALU_RLF)
      st[2] = res == 8'h00;
    return {res, st};
  endfunction

  // Kinds: 0 step, 1 jump, 2 call, 3 return, 4 status write, 5 pc low write
  task automatic step(input int k, input logic [8:0] t, input logic [7:0] d);
    flow = k == 1 ? FLOW_JUMP : k == 2 ? FLOW_CALL : k == 3 ? FLOW_RETURN : FLOW_STEP;
    jumpTarget = t;
    literal = d;
    fileWriteData = d;
    fileAddr = k == 4 ? 7'h03 : 7'h02;
    fileWrite = k > 3;
    case (k)
      0: expPc = expPc + 1'b1;
      1: expPc = {expSt[6:5], t};
      2:
      begin
        stk2 = stk1;
        stk1 = expPc + 1'b1;
        expPc = {expSt[6:5], 1'b0, t[7:0]};
      end
      3:
      begin
        expPc = stk1;
        stk1 = stk2;
      end
      4:
      begin
        expPc = expPc + 1'b1;
        expSt = {d[7:5], expSt[4:3], d[2:0]};
      end
      default: expPc = {expSt[6:5], 1'b0, d};
    endcase
    tick;
    chk(pc, expPc);
    chk(statusOut, expSt);
    if (k == 3)
      chk({retLiteralLoad, retLiteral}, {1'b1, d});
  endtask

  task automatic alu(input alu_op_t o, input logic [7:0] a, input logic [7:0] b, input logic dst);
    logic [15:0] e;
    e = alu_exp(o, a, b, expSt);
    aluOp = o;
    aluA = a;
    aluB = b;
    aluResult = e[15:8];
    flagWrite = 1'b1;
    fileWrite = dst;
    fileAddr = 7'h03;
    fileWriteData = e[15:8];
    flow = FLOW_STEP;
    expSt = dst ? {e[15:13], e[4:0]} : e[7:0];
    tick;
    chk(statusOut, expSt);
  endtask

  task automatic ind(input logic [6:0] p);
    flagWrite = 1'b0;
    fileAddr = 7'h04;
    fileWrite = 1'b1;
    fileWriteData = {1'b0, p};
    tick;
    chk(pointerOut, p);
    fileAddr = 7'h00;
    fileWriteData = ~{1'b0, p};
    #1;
    chk(memAddr, p);
    chk({memWrite, memWriteData}, {p != 7'h00, ~{1'b0, p}});
    chk(fileReadData, p == 7'h00 ? 8'h00 : {1'b0, p} ^ 8'h5a);
    tick;
  endtask

  task automatic measure(input logic [5:0] cfg, input logic w, input int e);
    int n;
    n = 0;
    fileWrite = 1'b0;
    workingReg = {2'b00, cfg};
    loadConfig = 1'b1;
    tick;
    loadConfig = 1'b0;
    watchdogTick = w;
    for (int i = 0; i < 80; i++)
    begin
      timerExtClockPin = i[2];
      tick;
      if (i >= 16)
        n += w ? watchdogTimeout : timerTick;
    end
    chk(n, e);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    expPc = 11'h7ff;
    stk1 = 11'h000;
    stk2 = 11'h000;
    expSt = 8'h18;
    repeat (16) @(posedge clk);
    #5;
    reset_n = 1'b1;
    chk(pc, expPc);
    chk({statusOut, pointerOut}, {expSt, 7'h00});
    instrValid = 1'b1;
    repeat (60)
    begin
      r = $random(seed);
      step(r[2:0] % 6, r[16:8], r[31:24]);
    end
    step(4, 9'h000, 8'h00);
    step(1, 9'h1ff, 8'h00);
    step(0, 9'h000, 8'h00);
    step(1, 9'h005, 8'h00);
    for (int i = 0; i < 6; i++)
      step(i < 3 ? 2 : 3, 9'(i * 37), 8'(i));
    alu(ALU_ADD, 8'hff, 8'h01, 1'b0);
    alu(ALU_SUB, 8'h10, 8'h01, 1'b1);
    alu(ALU_SUB, 8'h22, 8'h22, 1'b0);
    repeat (30)
    begin
      r = $random(seed);
      alu(ops[r[2:0] % 5], r[15:8], r[4] ? r[15:8] : r[23:16], r[5]);
    end
    foreach (ptrT[i])
      ind(ptrT[i]);
    sleepInstr = 1'b1;
    tick;
    sleepInstr = 1'b0;
    chk(statusOut[4:3], 2'b10);
    watchdogClear = 1'b1;
    tick;
    watchdogClear = 1'b0;
    chk(statusOut[4:3], 2'b11);
    foreach (cfgT[i])
      measure(cfgT[i], i > 5, expT[i]);
    chk(statusOut[4], 1'b0);
    close_out;
  end

  // The sequence needs about 860 cycles; 4000 leaves wide margin
  initial
  begin
    #200000;
    error_cnt++;
    close_out;
  end
endmodule // core_pc_status_stack_test
